// ===== ssc_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the three-wire port; its clock only runs inside a frame.
module ssc_host (
   output logic serial_clk, // serial clock
   output logic serial_latch_n, // enable, low in frame
   output logic serial_in_bit // serial data
);
   initial begin
      serial_clk = 1'b0;
      serial_latch_n = 1'b1;
      serial_in_bit = 1'b0;
   end
   task automatic send(input logic [3:0] a, input logic [17:0] d);
      logic [21:0] w;
      w = {d, a};
      serial_latch_n = 1'b0;
      for (int i = 21; i >= 0; i--) begin
         serial_in_bit = w[i];
         #24 serial_clk = 1'b1;
         #24 serial_clk = 1'b0;
      end
      serial_latch_n = 1'b1;
      // Released data is inverted so a stale bit cannot pass by luck.
      serial_in_bit = ~w[0];
      #400;
   endtask
endmodule
`default_nettype wire

// ===== ssc_pkg.sv
`default_nettype none
package ssc_pkg;
   localparam int WORD_W = 22;
   localparam int DATA_W = 18;
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_MAIN = 4'h0;
   localparam logic [3:0] ADDR_PWR = 4'h2;
   localparam logic [3:0] ADDR_RF1 = 4'h3;
   localparam logic [3:0] ADDR_RF2 = 4'h4;
   localparam logic [3:0] ADDR_IF = 4'h5;
   localparam int AUTO_PWR_BIT = 3;
   localparam int AUX_SEL_LO = 12;
   localparam int IF_EN_BIT = 1;
   localparam int RF_EN_BIT = 0;
   localparam int RF2_DIV_W = 17;
   localparam int IF_DIV_W = 16;
   localparam logic [1:0] AUX_LOW = 2'h1;
   localparam logic [1:0] AUX_LOCK = 2'h3;
   localparam logic [17:0] MAIN_RESET = 18'h00002;
   localparam logic [17:0] PWR_RESET = 18'h00000;
   localparam logic [17:0] DIV_RESET = 18'h00000;
   localparam int REF_DIVIDE = 65;
   localparam int REF_KHZ = 13000;
   localparam int CMP_KHZ = REF_KHZ / REF_DIVIDE;
   localparam int CORE_KHZ = 10000;
   // Comparison period in ns, and the 6.5-period tuning window in cycles.
   localparam int CMP_PERIOD_NS = 1000000 / CMP_KHZ;
   localparam int TUNE_HALF_PERIODS = 13;
   localparam int TUNE_NS = TUNE_HALF_PERIODS * CMP_PERIOD_NS / 2;
   localparam int CORE_PERIOD_NS = 1000000 / CORE_KHZ;
   localparam int TUNE_CYCLES = (TUNE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
   localparam int SETTLE_PERIODS = 21;
   localparam int TOTAL_PERIODS = 28;
   localparam int PRESCALE_MOD = 64;
   localparam int PRESCALE_SH = 6;
endpackage
`default_nettype wire

// ===== ssc_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Word is 18 data then 4 address bits.
// - Shift while latch low; commit on rise.
// - Start tuning on power-up or any write to a powered loop's divider.
// - Warning high while tuning or near range.
// - Warning is OR of both loop warnings.
// - Reference divide fixed at sixty-five.
// - RF band follows last written divider.
// - Prescaler and counters derived from divide.
// - Tuning lasts six and a half periods.
// - Power pin low turns both sections and reference amp off.
// - Pin high: enables from register or auto.
// - Bit 1 IF, bit 0 RF enable.
// - Reference amplifier on with section enables.
// - Auto-power bit forces both enables on.
// - Serial port works in every power state.
// - Aux select: 01 low, 11 warning.
// - Divider registers hold masked divide widths.
module ssc_regs (
   input wire logic core_clk, // core clock, 10 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic serial_clk, // serial clock from host
   input wire logic serial_latch_n, // serial enable, active low
   input wire logic serial_in_bit, // serial data
   input wire logic power_off_pin_n, // powerdown pin, low = off
   input wire logic if_range_warn, // IF loop nearing range limit
   input wire logic rf_range_warn, // RF loop nearing range limit
   output logic if_section_enable, // IF section powered
   output logic rf_section_enable, // RF section powered
   output logic ref_amp_enable, // reference amplifier powered
   output logic rf_band2_select, // 1 = RF2 VCO drives RF output
   output logic if_tuning, // IF loop self-tuning
   output logic rf_tuning, // RF loop self-tuning
   output logic lock_warning_n, // lock warning
   output logic aux_output_pin, // auxiliary output
   output logic [17:0] rf_band1_divide, // RF1 divide value
   output logic [16:0] rf_band2_divide, // RF2 divide value
   output logic [15:0] if_divide, // IF divide value
   output logic [5:0] rf_swallow, // swallow count, active band
   output logic [11:0] rf_main_count, // main counter, active band
   output logic [5:0] if_swallow, // IF swallow count
   output logic [11:0] if_main_count, // IF main counter
   output logic [6:0] ref_divide // fixed reference divide
);
   logic [21:0] word_s;
   // The serial clock may stop after the frame, so the latch level is
   // synchronised and its rise commits the word held still in word_s.
   logic latch_m_q, latch_s_q, latch_p_q;
   logic pin_m_q, pin_s_q;
   logic warn_if_m_q, warn_if_s_q, warn_rf_m_q, warn_rf_s_q;
   logic [17:0] main_q, main_d, pwr_q, pwr_d;
   logic [17:0] rf1_q, rf1_d;
   logic [16:0] rf2_q, rf2_d;
   logic [15:0] if_q, if_d;
   logic band2_q, band2_d;
   logic commit;
   logic [3:0] addr;
   logic [17:0] data;
   logic if_en, rf_en, if_en_q, rf_en_q;
   logic if_start, rf_start;
   logic [17:0] rf_active;
   logic [1:0] loop_start, loop_en, loop_tuning;

   ssc_shift i_ssc_shift (
      .serial_clk(serial_clk),
      .serial_latch_n(serial_latch_n),
      .serial_in_bit(serial_in_bit),
      .word_q(word_s)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_m_q <= 1'b1;
         latch_s_q <= 1'b1;
         latch_p_q <= 1'b1;
         pin_m_q <= 1'b0;
         pin_s_q <= 1'b0;
         warn_if_m_q <= 1'b0;
         warn_if_s_q <= 1'b0;
         warn_rf_m_q <= 1'b0;
         warn_rf_s_q <= 1'b0;
      end else begin
         latch_m_q <= serial_latch_n;
         latch_s_q <= latch_m_q;
         latch_p_q <= latch_s_q;
         pin_m_q <= power_off_pin_n;
         pin_s_q <= pin_m_q;
         warn_if_m_q <= if_range_warn;
         warn_if_s_q <= warn_if_m_q;
         warn_rf_m_q <= rf_range_warn;
         warn_rf_s_q <= warn_rf_m_q;
      end
   end

   // Commit does not look at the power pin, so writes land in any state.
   assign commit = latch_s_q & ~latch_p_q;
   assign addr = word_s[ssc_pkg::ADDR_W-1:0];
   assign data = word_s[ssc_pkg::WORD_W-1:ssc_pkg::ADDR_W];

   always_comb begin
      main_d = main_q;
      pwr_d = pwr_q;
      rf1_d = rf1_q;
      rf2_d = rf2_q;
      if_d = if_q;
      band2_d = band2_q;
      if (commit) begin
         case (addr)
            ssc_pkg::ADDR_MAIN: main_d = data;
            ssc_pkg::ADDR_PWR: pwr_d = data;
            ssc_pkg::ADDR_RF1: begin
               rf1_d = data;
               band2_d = 1'b0;
            end
            ssc_pkg::ADDR_RF2: begin
               rf2_d = data[ssc_pkg::RF2_DIV_W-1:0];
               band2_d = 1'b1;
            end
            ssc_pkg::ADDR_IF: if_d = data[ssc_pkg::IF_DIV_W-1:0];
            // Reserved addresses are ignored rather than stored.
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_q <= ssc_pkg::MAIN_RESET;
         pwr_q <= ssc_pkg::PWR_RESET;
         rf1_q <= ssc_pkg::DIV_RESET;
         rf2_q <= ssc_pkg::DIV_RESET[16:0];
         if_q <= ssc_pkg::DIV_RESET[15:0];
         band2_q <= 1'b0;
      end else begin
         main_q <= main_d;
         pwr_q <= pwr_d;
         rf1_q <= rf1_d;
         rf2_q <= rf2_d;
         if_q <= if_d;
         band2_q <= band2_d;
      end
   end

   always_comb begin
      if_en = 1'b0;
      rf_en = 1'b0;
      if (pin_s_q) begin
         if_en = pwr_q[ssc_pkg::IF_EN_BIT] |
            main_q[ssc_pkg::AUTO_PWR_BIT];
         rf_en = pwr_q[ssc_pkg::RF_EN_BIT] |
            main_q[ssc_pkg::AUTO_PWR_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         if_en_q <= 1'b0;
         rf_en_q <= 1'b0;
      end else begin
         if_en_q <= if_en;
         rf_en_q <= rf_en;
      end
   end

   // A rewrite with an unchanged value still counts as a retune request,
   // so the host can restart tuning on a warning by rewriting the divider.
   assign if_start = if_en & ((~if_en_q) |
      (commit & (addr == ssc_pkg::ADDR_IF)));
   assign rf_start = rf_en & ((~rf_en_q) |
      (commit & ((addr == ssc_pkg::ADDR_RF1) |
      (addr == ssc_pkg::ADDR_RF2))));

   // Index 1 is the IF loop and index 0 the RF loop, as in the power bits.
   assign loop_start = {if_start, rf_start};
   assign loop_en = {if_en, rf_en};

   for (genvar g = 0; g < 2; g++) begin : g_loop
      ssc_tuner i_ssc_tuner (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .start(loop_start[g]),
         .enabled(loop_en[g]),
         .tuning_q(loop_tuning[g])
      );
   end

   assign if_tuning = loop_tuning[1];
   assign rf_tuning = loop_tuning[0];

   // Range warnings are only meaningful from a powered loop.
   assign lock_warning_n = (if_tuning | (warn_if_s_q & if_en_q)) |
      (rf_tuning | (warn_rf_s_q & rf_en_q));

   always_comb begin
      case (main_q[ssc_pkg::AUX_SEL_LO+1:ssc_pkg::AUX_SEL_LO])
         ssc_pkg::AUX_LOCK: aux_output_pin = lock_warning_n;
         ssc_pkg::AUX_LOW: aux_output_pin = 1'b0;
         default: aux_output_pin = 1'b0;
      endcase
   end

   assign if_section_enable = if_en_q;
   assign rf_section_enable = rf_en_q;
   assign ref_amp_enable = if_en_q | rf_en_q;
   assign rf_band2_select = band2_q;
   assign rf_band1_divide = rf1_q;
   assign rf_band2_divide = rf2_q;
   assign if_divide = if_q;
   assign ref_divide = 7'(ssc_pkg::REF_DIVIDE);

   // Divide N = main * 64 + swallow for a 64/65 prescaler.
   assign rf_active = band2_q ? {1'b0, rf2_q} : rf1_q;
   assign rf_swallow = rf_active[ssc_pkg::PRESCALE_SH-1:0];
   assign rf_main_count = rf_active[17:ssc_pkg::PRESCALE_SH];
   assign if_swallow = if_q[ssc_pkg::PRESCALE_SH-1:0];
   assign if_main_count = {2'h0, if_q[15:ssc_pkg::PRESCALE_SH]};
endmodule
`default_nettype wire

// ===== ssc_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_regs_sva (
   input wire logic core_clk, // clock
   input wire logic rst_n, // reset
   input wire logic serial_latch_n, // enable
   input wire logic power_off_pin_n, // pin
   input wire logic if_range_warn, // warn
   input wire logic rf_range_warn, // warn
   input wire logic if_section_enable, // on
   input wire logic rf_section_enable, // on
   input wire logic ref_amp_enable, // on
   input wire logic rf_band2_select, // band
   input wire logic if_tuning, // tuning
   input wire logic rf_tuning, // tuning
   input wire logic lock_warning_n, // warning
   input wire logic aux_output_pin, // aux
   input wire logic [17:0] rf_band1_divide, // divide
   input wire logic [16:0] rf_band2_divide, // divide
   input wire logic [15:0] if_divide, // divide
   input wire logic [5:0] if_swallow, // swallow
   input wire logic [11:0] if_main_count, // count
   input wire logic [6:0] ref_divide // fixed
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // The tuning window is hundreds of cycles long, so it is counted here.
   logic [9:0] tune_cnt_q;
   logic [9:0] tune_cnt_d;
   always_comb begin
      tune_cnt_d = rf_tuning ? tune_cnt_q + 10'h001 : 10'h000;
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tune_cnt_q <= 10'h000;
      end else begin
         tune_cnt_q <= tune_cnt_d;
      end
   end
   a_pin_off: assert property (!power_off_pin_n [*5] |->
      !if_section_enable && !rf_section_enable) else $error("pin off");
   a_tune_warn: assert property (if_tuning || rf_tuning |->
      lock_warning_n) else $error("no warning while tuning");
   a_warn_or: assert property ((if_range_warn || rf_range_warn)[*5]
      ##0 (if_section_enable && rf_section_enable) |-> lock_warning_n)
      else $error("range warning lost");
   a_warn_clear: assert property ((!if_tuning && !rf_tuning &&
      !if_range_warn && !rf_range_warn)[*5] |-> !lock_warning_n)
      else $error("warning stuck");
   a_aux_pin: assert property (aux_output_pin |-> lock_warning_n)
      else $error("aux high without warning");
   a_ref_amp: assert property (ref_amp_enable ==
      (if_section_enable || rf_section_enable)) else $error("ref amp");
   a_ref_fixed: assert property (ref_divide == 7'h41)
      else $error("ref divide");
   a_tune_len: assert property ($fell(rf_tuning) && rf_section_enable
      |-> tune_cnt_q == 10'(ssc_pkg::TUNE_CYCLES)) else $error("tune len");
   a_div_hold: assert property (serial_latch_n [*8] |-> $stable(
      {rf_band1_divide, rf_band2_divide, if_divide, rf_band2_select}))
      else $error("register moved without a frame");
   a_if_split: assert property ($stable(if_divide) |->
      {if_main_count, if_swallow} == {2'h0, if_divide}) else $error("split");
   c_rf_tune: cover property ($fell(rf_tuning));
   c_band2: cover property ($rose(rf_band2_select));
   c_aux: cover property (aux_output_pin);
endmodule
bind ssc_regs ssc_regs_sva i_ssc_regs_sva (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .serial_latch_n(serial_latch_n),
   .power_off_pin_n(power_off_pin_n),
   .if_range_warn(if_range_warn),
   .rf_range_warn(rf_range_warn),
   .if_section_enable(if_section_enable),
   .rf_section_enable(rf_section_enable),
   .ref_amp_enable(ref_amp_enable),
   .rf_band2_select(rf_band2_select),
   .if_tuning(if_tuning),
   .rf_tuning(rf_tuning),
   .lock_warning_n(lock_warning_n),
   .aux_output_pin(aux_output_pin),
   .rf_band1_divide(rf_band1_divide),
   .rf_band2_divide(rf_band2_divide),
   .if_divide(if_divide),
   .if_swallow(if_swallow),
   .if_main_count(if_main_count),
   .ref_divide(ref_divide)
);
`default_nettype wire

// ===== ssc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_regs_tb;
   logic core_clk, rst_n, serial_clk, serial_latch_n, serial_in_bit;
   logic power_off_pin_n, if_range_warn, rf_range_warn;
   logic if_section_enable, rf_section_enable, ref_amp_enable;
   logic rf_band2_select, if_tuning, rf_tuning, lock_warning_n;
   logic aux_output_pin;
   logic [17:0] rf_band1_divide;
   logic [16:0] rf_band2_divide;
   logic [15:0] if_divide;
   logic [5:0] rf_swallow, if_swallow;
   logic [11:0] rf_main_count, if_main_count;
   logic [6:0] ref_divide;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   // Long enough for a full tuning window after a write returns.
   localparam int TUNE_WAIT = ssc_pkg::TUNE_CYCLES + 20;
   ssc_regs i_ssc_regs (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .serial_clk(serial_clk),
      .serial_latch_n(serial_latch_n),
      .serial_in_bit(serial_in_bit),
      .power_off_pin_n(power_off_pin_n),
      .if_range_warn(if_range_warn),
      .rf_range_warn(rf_range_warn),
      .if_section_enable(if_section_enable),
      .rf_section_enable(rf_section_enable),
      .ref_amp_enable(ref_amp_enable),
      .rf_band2_select(rf_band2_select),
      .if_tuning(if_tuning),
      .rf_tuning(rf_tuning),
      .lock_warning_n(lock_warning_n),
      .aux_output_pin(aux_output_pin),
      .rf_band1_divide(rf_band1_divide),
      .rf_band2_divide(rf_band2_divide),
      .if_divide(if_divide),
      .rf_swallow(rf_swallow),
      .rf_main_count(rf_main_count),
      .if_swallow(if_swallow),
      .if_main_count(if_main_count),
      .ref_divide(ref_divide)
   );
   ssc_host i_ssc_host (.serial_clk(serial_clk),
      .serial_latch_n(serial_latch_n), .serial_in_bit(serial_in_bit));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic chk(input string n, input logic [17:0] e,
                      input logic [17:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc_wait(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [17:0] d);
      i_ssc_host.send(a, d);
      cyc_wait(8);
   endtask
   task automatic end_of_test();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // A hung wait would otherwise never reach the verdict.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      rst_n <= 1'b0;
      power_off_pin_n <= 1'b1;
      if_range_warn <= 1'b0;
      rf_range_warn <= 1'b0;
      cyc_wait(4);
      rst_n <= 1'b1;
      cyc_wait(3);
      chk("if_en", 18'h0, if_section_enable);
      chk("ref_div", 18'd65, ref_divide);
      $display("reset test done");
      wr(4'h2, 18'h00003);
      chk("if_tune", 18'h1, if_tuning);
      chk("rf_tune", 18'h1, rf_tuning);
      chk("warn", 18'h1, lock_warning_n);
      chk("aux", 18'h0, aux_output_pin);
      cyc_wait(ssc_pkg::TUNE_CYCLES - 20);
      chk("rf_tune", 18'h1, rf_tuning);
      cyc_wait(30);
      chk("warn", 18'h0, lock_warning_n);
      wr(4'h0, 18'h03002);
      chk("aux", 18'h0, aux_output_pin);
      $display("power up test done");
      wr(4'h4, 18'h1a2b3);
      chk("band2", 18'h1, rf_band2_select);
      chk("rf2_div", 18'h1a2b3, rf_band2_divide);
      chk("rf_split", 18'h1a2b3, {rf_main_count, rf_swallow});
      chk("rf_tune", 18'h1, rf_tuning);
      cyc_wait(TUNE_WAIT);
      wr(4'h3, 18'h3ffff);
      chk("band2", 18'h0, rf_band2_select);
      chk("rf1_div", 18'h3ffff, rf_band1_divide);
      chk("rf_split", 18'h3ffff, {rf_main_count, rf_swallow});
      cyc_wait(TUNE_WAIT);
      wr(4'h5, 18'd7215);
      chk("if_div", 18'd7215, if_divide);
      chk("if_split", 18'd7215, {if_main_count, if_swallow});
      chk("if_tune", 18'h1, if_tuning);
      chk("rf_tune", 18'h0, rf_tuning);
      cyc_wait(TUNE_WAIT);
      wr(4'h6, 18'h0);
      wr(4'hf, 18'h0);
      chk("if_div", 18'd7215, if_divide);
      chk("rf_en", 18'h1, rf_section_enable);
      $display("divider test done");
      for (int i = 0; i < 4; i++) begin
         wr(4'h2, 18'(i));
         chk("if_en", 18'(i / 2), if_section_enable);
         chk("rf_en", 18'(i % 2), rf_section_enable);
         chk("ref_amp", 18'(i != 0), ref_amp_enable);
         cyc_wait(TUNE_WAIT);
      end
      wr(4'h2, 18'h0);
      wr(4'h0, 18'h0300a);
      chk("both_en", 18'h3, {if_section_enable, rf_section_enable});
      cyc_wait(TUNE_WAIT);
      power_off_pin_n <= 1'b0;
      cyc_wait(6);
      chk("both_en", 18'h0, {if_section_enable, rf_section_enable});
      wr(4'h5, 18'd7150);
      chk("if_div", 18'd7150, if_divide);
      chk("if_tune", 18'h0, if_tuning);
      power_off_pin_n <= 1'b1;
      cyc_wait(6);
      chk("if_tune", 18'h1, if_tuning);
      cyc_wait(TUNE_WAIT);
      $display("power test done");
      if_range_warn <= 1'b1;
      cyc_wait(6);
      chk("warn", 18'h1, lock_warning_n);
      if_range_warn <= 1'b0;
      rf_range_warn <= 1'b1;
      cyc_wait(6);
      chk("warn", 18'h1, lock_warning_n);
      chk("aux", 18'h1, aux_output_pin);
      wr(4'h0, 18'h0100a);
      chk("aux", 18'h0, aux_output_pin);
      rf_range_warn <= 1'b0;
      wr(4'h3, 18'h3ffff);
      wr(4'h5, 18'd7215);
      chk("rf_tune", 18'h1, rf_tuning);
      chk("if_tune", 18'h1, if_tuning);
      cyc_wait(TUNE_WAIT);
      chk("warn", 18'h0, lock_warning_n);
      $display("warning test done");
      end_of_test();
   end
endmodule
`default_nettype wire

// ===== ssc_shift.sv
`timescale 1ns/1ps
`default_nettype none
// Shift register in the serial clock domain; word is held until next frame.
module ssc_shift (
   input wire logic serial_clk, // link clock
   input wire logic serial_latch_n, // low while shifting
   input wire logic serial_in_bit, // serial data
   output logic [21:0] word_q // last bits shifted in
);
   logic [21:0] word_d;
   always_comb begin
      word_d = word_q;
      if (!serial_latch_n) begin
         word_d = {word_q[20:0], serial_in_bit};
      end
   end
   always_ff @(posedge serial_clk) begin
      word_q <= word_d;
   end
endmodule
`default_nettype wire

// ===== ssc_tuner.sv
`timescale 1ns/1ps
`default_nettype none
// One loop's self-tuning timer: busy for the tuning window after a start.
module ssc_tuner (
   input wire logic core_clk, // core clock
   input wire logic rst_n, // async reset
   input wire logic start, // one-cycle start pulse
   input wire logic enabled, // loop powered
   output logic tuning_q // loop is self-tuning
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic tuning_d;
   always_comb begin
      cnt_d = cnt_q;
      tuning_d = tuning_q;
      if (!enabled) begin
         tuning_d = 1'b0;
         cnt_d = 16'h0000;
      end else if (start) begin
         tuning_d = 1'b1;
         cnt_d = 16'(ssc_pkg::TUNE_CYCLES - 1);
      end else if (tuning_q) begin
         if (cnt_q == 16'h0000) begin
            tuning_d = 1'b0;
         end else begin
            cnt_d = cnt_q - 16'h0001;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 16'h0000;
         tuning_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tuning_q <= tuning_d;
      end
   end
endmodule
`default_nettype wire
